// >>> bench/sbs_ctrl_model.sv
// sbs_ctrl_model: controller side of the burst sram bus
// assumes: op is called from one process, one cycle per call
`timescale 1ns/10ps
`default_nettype none
module sbs_ctrl_model
  import sbs_pkg::*;
(
  input  wire logic        i_clk_sys,
  output var sbs_ctrl_s    o_ctrl,
  output logic [3:0]       o_lane_write_n,
  output logic [17:0]      o_addr,
  output logic [35:0]      o_dq,
  output logic             o_oe_n
);
  logic oe_off = 1'b0;
  initial begin
    o_ctrl = 8'hDF;
    o_lane_write_n = 4'hF;
    o_addr = 18'h00000;
    o_dq = 36'h000000000;
    o_oe_n = 1'b1;
  end
  // k: 0 proc read, 1 ctrl begin, 2 continue, 3 suspend, 4 deselect
  task automatic op(input logic [2:0] k, input logic [17:0] a, input logic gw, input logic [3:0] ln,
                    input logic [35:0] d);
    logic wr;
    wr = (!gw || !(&ln)) && k != 3'h0;
    @(posedge i_clk_sys);
    o_ctrl <= {k == 3'h4, 1'b1, 1'b0, k != 3'h0, k != 3'h1 && k != 3'h4, k != 3'h2, gw, &ln};
    o_lane_write_n <= ln;
    o_addr <= a;
    o_dq <= wr ? d : ~o_dq;
    o_oe_n <= wr || oe_off;
  endtask
endmodule
`default_nettype wire

// >>> bench/sbs_sram_core_properties.sv
// sbs_sram_core_properties: port checks of the burst sram core
// assumes: bound to sbs_sram_core, one clock
`timescale 1ns/10ps
`default_nettype none
module sbs_sram_core_properties
  import sbs_pkg::*;
#(
  parameter int unsigned P_LANES = 4,
  parameter int unsigned P_DW    = 36
)
(
  input wire logic               i_clk_sys,
  input wire logic               i_rst_n,
  input wire sbs_ctrl_s          i_ctrl,
  input wire logic [P_LANES-1:0] i_lane_write_n,
  input wire logic               i_oe_n,
  input wire logic [P_DW-1:0]    o_dq,
  input wire logic [P_DW-1:0]    o_dq_oe_n
);
  logic sel;
  logic wt;
  logic cont;
  assign sel  = !i_ctrl.chip_sel_n && i_ctrl.depth_select_hi && !i_ctrl.depth_select_lo_n;
  assign wt   = !i_ctrl.global_write_n || (!i_ctrl.lane_write_gate_n && !(&i_lane_write_n));
  assign cont = i_ctrl.ctrl_addr_strobe_n && (i_ctrl.proc_addr_strobe_n || i_ctrl.chip_sel_n);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence s_rd_begin; sel && !i_ctrl.proc_addr_strobe_n; endsequence
  sequence s_rd_hold; cont && i_ctrl.burst_advance_n && !wt; endsequence
  reset_quiet_a: assert property (disable iff (1'b0) !i_rst_n |=> &o_dq_oe_n)
    else $error("drivers on in reset");
  oe_gates_a: assert property (i_oe_n |-> &o_dq_oe_n)
    else $error("drivers on with oe high");
  desel_off_a: assert property (i_ctrl.chip_sel_n && !i_ctrl.ctrl_addr_strobe_n |=> &o_dq_oe_n)
    else $error("drivers on after deselect");
  proc_read_a: assert property (s_rd_begin |=> i_oe_n || o_dq_oe_n == '0)
    else $error("no read after proc strobe");
  ctrl_write_a: assert property (sel && i_ctrl.proc_addr_strobe_n && !i_ctrl.ctrl_addr_strobe_n && wt
    |=> &o_dq_oe_n) else $error("drivers on in write begin");
  cont_write_a: assert property (cont && wt |=> &o_dq_oe_n)
    else $error("drivers on in write");
  hold_read_a: assert property (s_rd_begin ##1 s_rd_hold |=> i_oe_n || $past(i_oe_n) || o_dq == $past(o_dq))
    else $error("suspended read moved");
  idle_zero_a: assert property (&o_dq_oe_n |-> o_dq == '0)
    else $error("undriven data not zero");
endmodule
bind sbs_sram_core sbs_sram_core_properties #(.P_LANES(P_LANES), .P_DW(P_DW)) u_props (.i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n), .i_ctrl(i_ctrl), .i_lane_write_n(i_lane_write_n), .i_oe_n(i_oe_n), .o_dq(o_dq),
  .o_dq_oe_n(o_dq_oe_n));
`default_nettype wire

// >>> bench/test_sync_burst_sram_control.sv
// test_sync_burst_sram_control: scenario bench for the burst sram core
// assumes: sbs_ctrl_model drives the bus pins
`timescale 1ns/10ps
`default_nettype none
module test_sync_burst_sram_control;
  import sbs_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        order = 1'b1;
  int          err_count = 0;
  int          n_compared = 0;
  sbs_ctrl_s   ctrl;
  logic [3:0]  lw;
  logic [17:0] addr;
  logic [35:0] dq, q, q_oe_n;
  logic        oe_n;
  always #5 clk = ~clk;
  sbs_sram_core u_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ctrl(ctrl), .i_lane_write_n(lw), .i_addr(addr),
    .i_dq(dq), .i_oe_n(oe_n), .i_burst_order(order), .o_dq(q), .o_dq_oe_n(q_oe_n));
  sbs_ctrl_model u_ctl (.i_clk_sys(clk), .o_ctrl(ctrl), .o_lane_write_n(lw), .o_addr(addr), .o_dq(dq),
    .o_oe_n(oe_n));
  function automatic logic [35:0] word(input int j);
    return 36'h123456780 + j;
  endfunction
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic op(input logic [2:0] k, input logic [1:0] lo, input logic gw, input logic [3:0] ln,
                    input logic [35:0] d);
    u_ctl.op(k, {16'h0ABC, lo}, gw, ln, d);
  endtask
  task automatic test_done;
    if (err_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_burst_wr;
    op(3'h1, 2'h2, 1'b0, 4'hF, word(0));
    for (int j = 1; j < 4; j++) op(3'h2, 2'h0, 1'b0, 4'hF, word(j));
    for (int j = 0; j < 4; j++) begin
      op(3'h0, 2'h2 ^ j[1:0], 1'b1, 4'hF, 36'h0);
      op(3'h3, 2'h0, 1'b1, 4'hF, 36'h0);
      #1 chk("interleaved", word(j), q);
    end
  endtask
  task automatic t_linear;
    @(posedge clk) order <= 1'b0;
    op(3'h0, 2'h1, 1'b1, 4'hF, 36'h0);
    for (int j = 0; j < 4; j++) begin
      op((j < 3) ? 3'h2 : 3'h4, 2'h0, 1'b1, 4'hF, 36'h0);
      #1 chk("linear", word(((j + 1) % 4) ^ 2), q);
    end
    chk("drive", 36'h0, q_oe_n);
  endtask
  task automatic t_lanes;
    op(3'h0, 2'h2, 1'b0, 4'h0, 36'hFFFFFFFFF);
    op(3'h3, 2'h0, 1'b1, 4'hF, 36'h0);
    #1 chk("read ignores write", word(0), q);
    op(3'h3, 2'h0, 1'b1, 4'hD, 36'h0);
    op(3'h3, 2'h0, 1'b1, 4'h7, 36'h0);
    op(3'h0, 2'h2, 1'b1, 4'hF, 36'h0);
    op(3'h4, 2'h0, 1'b1, 4'hF, 36'h0);
    #1 chk("lanes", word(0) & 36'h007FC01FF, q);
  endtask
  task automatic t_desel;
    u_ctl.oe_off = 1'b1;
    op(3'h0, 2'h2, 1'b1, 4'hF, 36'h0);
    op(3'h3, 2'h0, 1'b1, 4'hF, 36'h0);
    #1 chk("oe high", {36{1'b1}}, q_oe_n);
    u_ctl.oe_off = 1'b0;
    op(3'h4, 2'h0, 1'b1, 4'hF, 36'h0);
    op(3'h2, 2'h0, 1'b1, 4'hF, 36'h0);
    op(3'h3, 2'h0, 1'b1, 4'hF, 36'h0);
    #1 chk("deselect", {36{1'b1}}, q_oe_n);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("reset", {36{1'b1}}, q_oe_n);
    t_burst_wr;
    t_linear;
    t_lanes;
    t_desel;
    test_done;
  end
  initial begin
    #20000;
    err_count++;
    test_done;
  end
endmodule
`default_nettype wire

// >>> design/sbs_burst_seq.sv
// sbs_burst_seq: low two address bits for a burst position
// assumes: start bits and position come from the core's registered state
`timescale 1ns/10ps
`default_nettype none

module sbs_burst_seq
  import sbs_pkg::*;
(
  input  wire logic [1:0] i_start,
  input  wire logic [1:0] i_pos,
  input  wire logic       i_interleave,
  output logic      [1:0] o_addr_lo
);

  always_comb begin
    if (i_interleave) begin
      o_addr_lo = i_start ^ i_pos;
    end else begin
      o_addr_lo = 2'(i_start + i_pos);
    end
  end

endmodule

`default_nettype wire

// >>> design/sbs_pkg.sv
// sbs_pkg: constants, pin bundle and state record for the burst sram core
// assumes: one system clock; the memory controller is synchronous to it
package sbs_pkg;

  // lane geometry of the two organisations
  localparam int unsigned SBS_LANE_BITS = 9;
  localparam int unsigned SBS_LANES_X36 = 4;
  localparam int unsigned SBS_LANES_X18 = 2;
  localparam int unsigned SBS_AW_X36    = 18;
  localparam int unsigned SBS_AW_X18    = 19;
  localparam int unsigned SBS_AW_MAX    = 19;

  // burst counter
  localparam int unsigned SBS_CNT_W     = 2;
  localparam logic [1:0]  SBS_CNT_RST   = 2'h0;
  localparam logic [1:0]  SBS_CNT_STEP  = 2'h1;

  // values after reset
  localparam logic [18:0] SBS_ADDR_RST  = 19'h00000;
  localparam logic        SBS_ACT_RST   = 1'b0;
  localparam logic        SBS_RD_RST    = 1'b0;

  // cycle kinds, gray along idle -> begin -> continue -> suspend
  typedef enum logic [1:0] {
    SBS_CYC_IDLE    = 2'h0,
    SBS_CYC_BEGIN   = 2'h1,
    SBS_CYC_CONT    = 2'h3,
    SBS_CYC_SUSPEND = 2'h2
  } sbs_cyc_e;

  // synchronous control pins, all sampled on the rising edge
  typedef struct packed {
    logic chip_sel_n;
    logic depth_select_hi;
    logic depth_select_lo_n;
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_advance_n;
    logic global_write_n;
    logic lane_write_gate_n;
  } sbs_ctrl_s;

  // whole state of the core
  typedef struct packed {
    sbs_cyc_e     cyc;
    logic         active;
    logic         rd;
    logic [1:0]   start;
    logic [1:0]   cnt;
    logic [18:0]  addr;
  } sbs_state_s;

endpackage

// >>> design/sbs_sram_core.sv
// sbs_sram_core: flow-through synchronous burst sram, control and array
// assumes: control, address and data pins are synchronous to i_clk_sys;
// output enable and burst order pins may change at any time
`timescale 1ns/10ps
`default_nettype none

module sbs_sram_core
  import sbs_pkg::*;
#(
  parameter int unsigned P_LANES = SBS_LANES_X36,
  parameter int unsigned P_AW    = (P_LANES == SBS_LANES_X36) ? SBS_AW_X36 : SBS_AW_X18,
  parameter int unsigned P_DW    = P_LANES * SBS_LANE_BITS
)
(
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst_n,
  input  wire sbs_ctrl_s          i_ctrl,
  input  wire logic [P_LANES-1:0] i_lane_write_n,
  input  wire logic [P_AW-1:0]    i_addr,
  input  wire logic [P_DW-1:0]    i_dq,
  input  wire logic               i_oe_n,
  input  wire logic               i_burst_order,
  output logic      [P_DW-1:0]    o_dq,
  output logic      [P_DW-1:0]    o_dq_oe_n
);

  sbs_state_s         state;
  sbs_state_s         next_state;

  logic               sel_all;
  logic               proc_start;
  logic               ctrl_start;
  logic               deselect;
  logic               begin_rd;
  logic               begin_ext;
  logic               cont_cyc;
  logic               write_term;
  logic [P_LANES-1:0] lane_we;
  logic [1:0]         step_pos;
  logic [1:0]         step_lo;
  logic               do_write;
  logic [P_AW-1:0]    wr_addr;
  logic [P_AW-1:0]    rd_addr;
  logic [P_DW-1:0]    rd_data;
  logic               drive;

  // chip fully selected: primary low, high depth select high, low one low
  assign sel_all    = !i_ctrl.chip_sel_n && i_ctrl.depth_select_hi && !i_ctrl.depth_select_lo_n;

  // processor strobe counts only while the primary select is low
  assign proc_start = !i_ctrl.proc_addr_strobe_n && !i_ctrl.chip_sel_n;
  assign ctrl_start = !i_ctrl.ctrl_addr_strobe_n;

  // deselect when a strobe is taken but not every select agrees
  assign deselect   = (proc_start || ctrl_start) && !sel_all;
  assign begin_rd   = proc_start && sel_all;
  assign begin_ext  = !proc_start && ctrl_start && sel_all;
  assign cont_cyc   = !proc_start && !ctrl_start;

  // per-lane enables; the two-lane build simply has fewer of them
  genvar g;
  generate
    for (g = 0; g < P_LANES; g++) begin : g_lane_we
      assign lane_we[g] = !i_ctrl.global_write_n
                          || (!i_ctrl.lane_write_gate_n && !i_lane_write_n[g]);
    end
  endgenerate

  // write term: any lane enabled means a write cycle
  assign write_term = |lane_we;

  // next burst position from the registered count
  assign step_pos   = 2'(state.cnt + SBS_CNT_STEP);

  sbs_burst_seq u_burst_seq (
    .i_start      (state.start),
    .i_pos        (step_pos),
    .i_interleave (i_burst_order),
    .o_addr_lo    (step_lo)
  );

  always_comb begin
    next_state = state;
    if (deselect) begin
      next_state.cyc    = SBS_CYC_IDLE;
      next_state.active = 1'b0;
      next_state.rd     = 1'b0;
    end else if (begin_rd) begin
      next_state.cyc    = SBS_CYC_BEGIN;
      next_state.active = 1'b1;
      next_state.rd     = 1'b1;
      next_state.start  = i_addr[1:0];
      next_state.cnt    = SBS_CNT_RST;
      next_state.addr   = SBS_AW_MAX'(i_addr);
    end else if (begin_ext) begin
      next_state.cyc    = SBS_CYC_BEGIN;
      next_state.active = 1'b1;
      next_state.rd     = !write_term;
      next_state.start  = i_addr[1:0];
      next_state.cnt    = SBS_CNT_RST;
      next_state.addr   = SBS_AW_MAX'(i_addr);
    end else if (cont_cyc && state.active) begin
      next_state.rd = !write_term;
      if (!i_ctrl.burst_advance_n) begin
        next_state.cyc  = SBS_CYC_CONT;
        next_state.cnt  = step_pos;
        next_state.addr = {state.addr[SBS_AW_MAX-1:2], step_lo};
      end else begin
        next_state.cyc  = SBS_CYC_SUSPEND;
      end
    end
  end

  // a write lands at the address of the cycle now being taken
  assign do_write = next_state.active && !next_state.rd;
  assign wr_addr  = next_state.addr[P_AW-1:0];
  assign rd_addr  = state.addr[P_AW-1:0];

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state.cyc    <= SBS_CYC_IDLE;
      state.active <= SBS_ACT_RST;
      state.rd     <= SBS_RD_RST;
      state.start  <= SBS_CNT_RST;
      state.cnt    <= SBS_CNT_RST;
      state.addr   <= SBS_ADDR_RST;
    end else begin
      state <= next_state;
    end
  end

  // one array per lane, written with the command edge's data
  generate
    for (g = 0; g < P_LANES; g++) begin : g_lane_mem
      logic [SBS_LANE_BITS-1:0] mem [0:(1<<P_AW)-1];

      always_ff @(posedge i_clk_sys) begin
        if (i_rst_n && do_write && lane_we[g]) begin
          mem[wr_addr] <= i_dq[g*SBS_LANE_BITS +: SBS_LANE_BITS];
        end
      end

      // flow-through read of the registered address
      assign rd_data[g*SBS_LANE_BITS +: SBS_LANE_BITS] = mem[rd_addr];
    end
  endgenerate

  // output enable gates the drivers without any clock
  assign drive     = state.active && state.rd && !i_oe_n;
  assign o_dq      = drive ? rd_data : '0;
  assign o_dq_oe_n = drive ? '0 : '1;

endmodule

`default_nettype wire
